// file: logic/wdt_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"

// watchdog counter, timeout handling and reload bytes
module wdt_core #(
   parameter int CNT_W = 24   // counter width, three bytes
) (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   // register write port (same clock domain)
   input  wire logic        wr_en_i,
   input  wire logic [11:0] wr_addr_i,
   input  wire logic [7:0]  wr_data_i,
   // register read port
   input  wire logic        rd_en_i,
   input  wire logic [11:0] rd_addr_i,
   output logic [7:0]       rd_data_o,
   // control inputs
   input  wire logic        wdt_enable_i,
   input  wire logic        refresh_i,
   input  wire logic        reset_on_timeout_i,
   input  wire logic        stop_mode_i,
   input  wire logic        flags_clear_i,
   // outputs
   output logic             sys_reset_req_o,
   output logic             stop_recovery_o,
   output logic             timeout_status_flag_o,
   output logic             stop_flag_o,
   output logic [23:0]      counter_o
);
   // ==========================================
   // elaboration checks
   if (CNT_W != 24) begin : g_bad_width
      $error("counter width must be 24");
   end

   // ==========================================
   // state
   typedef struct packed {
      logic [7:0]  rld_u;     // reload upper byte
      logic [7:0]  rld_h;     // reload high byte
      logic [7:0]  rld_l;     // reload low byte
      logic [23:0] cnt;       // down counter
      logic        en_prev;   // enable delayed, for edge
      logic        tout;      // timeout status flag
      logic        stopf;     // stop indication flag
      logic        rst_req;   // system reset pulse
      logic        smr;       // stop recovery pulse
      logic [7:0]  rdat;      // read data
   } core_regs_t;

   core_regs_t r_q;   // registered state
   core_regs_t r_d;   // next state

   logic g_u;         // upper byte write accepted
   logic g_h;         // high byte write accepted
   logic g_l;         // low byte write accepted
   logic swallow;     // unlock write, control untouched
   logic [23:0] rld;  // assembled reload value
   logic expire;      // counter reaching zero this cycle

   // ==========================================
   // lock sequencer
   wdt_lock_fsm u_lock (
      .mclk_i        (mclk_i),
      .nrst_i        (nrst_i),
      .wr_en_i       (wr_en_i),
      .wr_addr_i     (wr_addr_i),
      .wr_data_i     (wr_data_i),
      .grant_u_o     (g_u),
      .grant_h_o     (g_h),
      .grant_l_o     (g_l),
      .ctl_swallow_o (swallow)
   );

   assign rld = {r_q.rld_u, r_q.rld_h, r_q.rld_l}; // see [R11]
   assign expire = r_q.en_prev && (r_q.cnt == `WDT_CNT_ZERO + 24'h000001);

   // ==========================================
   // next-state logic
   always_comb begin
      r_d = r_q;
      r_d.rst_req = 1'b0;
      r_d.smr = 1'b0;
      r_d.en_prev = wdt_enable_i;
      // reload bytes only on granted steps
      if (g_u) r_d.rld_u = wr_data_i; // see [R8]
      if (g_h) r_d.rld_h = wr_data_i;
      if (g_l) r_d.rld_l = wr_data_i;
      // unlock writes do not alter control state; other
      // control writes are not modelled beyond the flags
      if (swallow) r_d.tout = r_q.tout; // see [R5]
      // software clear, lower priority than a new timeout
      if (flags_clear_i) begin
         r_d.tout = 1'b0;
         r_d.stopf = 1'b0;
      end
      // counter
      if (wdt_enable_i && (!r_q.en_prev || refresh_i)) begin
         r_d.cnt = rld; // see [R9]
      end else if (wdt_enable_i && r_q.cnt != `WDT_CNT_ZERO) begin
         r_d.cnt = r_q.cnt - 24'h000001; // see [R11]
      end
      // timeout handling, set wins over clear
      if (wdt_enable_i && expire && !refresh_i && reset_on_timeout_i) begin
         r_d.tout = 1'b1; // see [R1]
         if (stop_mode_i) begin
            r_d.smr = 1'b1; // see [R2]
            r_d.stopf = 1'b1; // see [R3]
         end else begin
            r_d.rst_req = 1'b1; // see [R1]
         end
      end
      // write-only control: its address reads zero
      r_d.rdat = 8'h00; // see [R10]
      if (rd_en_i) begin
         case (rd_addr_i)
            `WDT_ADDR_RLD_U: r_d.rdat = r_q.rld_u;
            `WDT_ADDR_RLD_H: r_d.rdat = r_q.rld_h;
            `WDT_ADDR_RLD_L: r_d.rdat = r_q.rld_l;
            default:         r_d.rdat = 8'h00;
         endcase
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // byte slices of the reload reset value, cut on purpose
         r_q.rld_u   <= 8'(`WDT_RLD_RESET >> 16);
         r_q.rld_h   <= 8'(`WDT_RLD_RESET >> 8);
         r_q.rld_l   <= 8'(`WDT_RLD_RESET);
         r_q.cnt     <= `WDT_CNT_ZERO;
         r_q.en_prev <= 1'b0;
         r_q.tout    <= 1'b0;
         r_q.stopf   <= 1'b0;
         r_q.rst_req <= 1'b0;
         r_q.smr     <= 1'b0;
         r_q.rdat    <= 8'h00;
      end else begin
         r_q <= r_d;
      end
   end

   // ==========================================
   // outputs
   assign sys_reset_req_o       = r_q.rst_req;
   assign stop_recovery_o       = r_q.smr;
   assign timeout_status_flag_o = r_q.tout;
   assign stop_flag_o           = r_q.stopf;
   assign counter_o             = r_q.cnt;
   assign rd_data_o             = r_q.rdat;
endmodule
`default_nettype wire

// file: logic/wdt_defines.svh
// Contract
// [R1] normal-mode timeout: system reset, set status flag
// [R2] stop-mode timeout starts stop recovery instead
// [R3] stop timeout sets status and stop flags
// [R4] software writes 55H then AAH first
// [R5] unlock writes leave control bits unchanged
// [R6] software writes upper, high, low in order
// [R7] stray write resets lock machine
// [R8] reload writes ignored unless unlocked
// [R9] reload copied to counter on enable, refresh
// [R10] control register write-only, reads unreliable
// [R11] upper:high:low form 24-bit countdown to zero
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================
// register addresses (byte bus, 12-bit space)
`define WDT_ADDR_CTL     12'hFF0
`define WDT_ADDR_RLD_U   12'hFF1
`define WDT_ADDR_RLD_H   12'hFF2
`define WDT_ADDR_RLD_L   12'hFF3

// ==========================================
// unlock pattern
`define WDT_UNLOCK_1     8'h55
`define WDT_UNLOCK_2     8'hAA

// ==========================================
// control bit positions and reset values
`define WDT_CTL_BIT_STOP    1
`define WDT_CTL_BIT_STATUS  0
`define WDT_RLD_RESET       24'hFFFFFF
`define WDT_CNT_ZERO        24'h000000

`endif

// file: logic/wdt_lock_fsm.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"

// unlock-and-reload sequencer for the reload bytes
module wdt_lock_fsm (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       nrst_i,
   // register write strobe
   input  wire logic       wr_en_i,
   input  wire logic [11:0] wr_addr_i,
   input  wire logic [7:0] wr_data_i,
   // reload byte write grants
   output logic            grant_u_o,
   output logic            grant_h_o,
   output logic            grant_l_o,
   // unlock pattern seen on control address
   output logic            ctl_swallow_o
);
   // ==========================================
   // state
   typedef struct packed {
      wdt_pkg::lock_state_t st;
   } lock_regs_t;

   lock_regs_t r_q;   // registered state
   lock_regs_t r_d;   // next state

   logic to_ctl;      // write hits control address
   logic to_u;        // write hits upper byte
   logic to_h;        // write hits high byte
   logic to_l;        // write hits low byte

   assign to_ctl = wr_addr_i == `WDT_ADDR_CTL;
   assign to_u   = wr_addr_i == `WDT_ADDR_RLD_U;
   assign to_h   = wr_addr_i == `WDT_ADDR_RLD_H;
   assign to_l   = wr_addr_i == `WDT_ADDR_RLD_L;

   // ==========================================
   // sequence tracking
   always_comb begin
      r_d = r_q;
      grant_u_o = 1'b0;
      grant_h_o = 1'b0;
      grant_l_o = 1'b0;
      ctl_swallow_o = 1'b0;
      if (wr_en_i) begin
         // any write not matching the next step drops the lock, except a repeated 55H, which restarts at LK_GOT_55
         r_d.st = wdt_pkg::LK_IDLE; // see [R7]
         case (r_q.st)
            wdt_pkg::LK_IDLE: begin
               if (to_ctl && wr_data_i == `WDT_UNLOCK_1) begin
                  r_d.st = wdt_pkg::LK_GOT_55; // see [R4]
                  ctl_swallow_o = 1'b1; // see [R5]
               end
            end
            wdt_pkg::LK_GOT_55: begin
               if (to_ctl && wr_data_i == `WDT_UNLOCK_2) begin
                  r_d.st = wdt_pkg::LK_OPEN_U;
                  ctl_swallow_o = 1'b1; // see [R5]
               end else if (to_ctl && wr_data_i == `WDT_UNLOCK_1) begin
                  // restart from the first byte
                  r_d.st = wdt_pkg::LK_GOT_55;
                  ctl_swallow_o = 1'b1;
               end
            end
            wdt_pkg::LK_OPEN_U: begin
               if (to_u) begin
                  r_d.st = wdt_pkg::LK_OPEN_H; // see [R6]
                  grant_u_o = 1'b1; // see [R8]
               end
            end
            wdt_pkg::LK_OPEN_H: begin
               if (to_h) begin
                  r_d.st = wdt_pkg::LK_OPEN_L;
                  grant_h_o = 1'b1; // see [R8]
               end
            end
            wdt_pkg::LK_OPEN_L: begin
               // sequence complete after the low byte
               if (to_l) begin
                  grant_l_o = 1'b1; // see [R8]
               end
            end
            default: r_d.st = wdt_pkg::LK_IDLE;
         endcase
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r_q.st <= wdt_pkg::LK_IDLE;
      end else begin
         r_q <= r_d;
      end
   end
endmodule
`default_nettype wire

// file: logic/wdt_pkg.sv
package wdt_pkg;
   // lock sequence states
   typedef enum logic [2:0] {
      LK_IDLE,
      LK_GOT_55,
      LK_OPEN_U,
      LK_OPEN_H,
      LK_OPEN_L
   } lock_state_t;
endpackage

// file: tb/watchdog_reset_and_reload_lock_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module watchdog_reset_and_reload_lock_test;
   // ==========================================
   // nets, model of the reload value, counters
   logic        mclk_i, nrst_i, wr_en_i, rd_en_i, wdt_enable_i, refresh_i;
   logic        reset_on_timeout_i, stop_mode_i, flags_clear_i;
   logic [11:0] wr_addr_i, rd_addr_i;
   logic [7:0]  wr_data_i, rd_data_o;
   logic        sys_reset_req_o, stop_recovery_o, timeout_status_flag_o, stop_flag_o;
   logic [23:0] counter_o, rl;
   int          err_total, num_checks;
   int          stray [6] = '{0, 1, 2, 3, 4, 5}; // stray write before this step, 0 none
   wdt_core dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
      .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
      .wdt_enable_i(wdt_enable_i), .refresh_i(refresh_i), .reset_on_timeout_i(reset_on_timeout_i),
      .stop_mode_i(stop_mode_i), .flags_clear_i(flags_clear_i), .sys_reset_req_o(sys_reset_req_o),
      .stop_recovery_o(stop_recovery_o), .timeout_status_flag_o(timeout_status_flag_o),
      .stop_flag_o(stop_flag_o), .counter_o(counter_o));
   // ==========================================
   // tasks
   task automatic stop_test();
      if (err_total == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // strobe stays high so writes run back to back
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      wr_en_i = 1'h1;
      wr_addr_i = a;
      wr_data_i = d;
      @(negedge mclk_i);
   endtask
   task automatic idle();
      wr_en_i = 1'h0;
      @(negedge mclk_i);
   endtask
   // unlock and write v; a stray write after step one breaks the chain
   task automatic seq(input int st, input logic [23:0] v);
      logic       ab;
      logic [7:0] b;
      ab = 1'h0;
      for (int k = 1; k <= 5; k++) begin
         b = (k == 1) ? 8'h55 : (k == 2) ? 8'hAA : v[(5 - k) * 8 +: 8];
         if (k == st) begin
            wr(12'h100, 8'h00);
            ab = (k > 1);
         end
         wr((k < 3) ? `WDT_ADDR_CTL : `WDT_ADDR_CTL + 12'(k - 2), b);
         if (k > 2 && !ab) rl[(5 - k) * 8 +: 8] = b;
      end
      idle();
   endtask
   // enable pulse loads the counter
   task automatic ld();
      wdt_enable_i = 1'h1;
      @(negedge mclk_i);
      `CHK("counter", rl, counter_o)
      wdt_enable_i = 1'h0;
      @(negedge mclk_i);
   endtask
   // bounded wait for a timeout pulse
   task automatic wt(input logic s);
      for (int j = 0; j < 12; j++) begin
         @(negedge mclk_i);
         if ((s ? stop_recovery_o : sys_reset_req_o) === 1'h1) return;
      end
      err_total++;
      $display("MISMATCH timeout pulse exp 1 got 0");
      stop_test();
   endtask
   initial begin
      mclk_i = 1'h0;
      forever #4 mclk_i = ~mclk_i;
   end
   // ==========================================
   // main sequence
   initial begin
      {nrst_i, wr_en_i, rd_en_i, wdt_enable_i, refresh_i, stop_mode_i, flags_clear_i} = '0;
      {wr_addr_i, rd_addr_i, wr_data_i} = '0;
      reset_on_timeout_i = 1'h1;
      err_total = 0;
      num_checks = 0;
      rl = 24'hFFFFFF;
      repeat (3) @(negedge mclk_i);
      `CHK("reset count", 24'h000000, counter_o)
      `CHK("reset flags", 2'h0, {timeout_status_flag_o, stop_flag_o})
      nrst_i = 1'h1;
      ld();
      for (int i = 0; i < 6; i++) begin
         seq(stray[i], {8'h10 + 8'(i), 8'h20 + 8'(i), 8'h30 + 8'(i)});
         ld();
      end
      // reload byte written while locked
      wr(`WDT_ADDR_RLD_L, 8'h77);
      idle();
      ld();
      // short period, refresh mid-count, normal timeout
      seq(0, 24'h000003);
      wdt_enable_i = 1'h1;
      repeat (2) @(negedge mclk_i);
      refresh_i = 1'h1;
      @(negedge mclk_i);
      refresh_i = 1'h0;
      `CHK("refresh", 24'h000003, counter_o)
      wt(1'h0);
      `CHK("normal flags", 3'h4, {timeout_status_flag_o, stop_flag_o, stop_recovery_o})
      `CHK("count end", 24'h000000, counter_o)
      flags_clear_i = 1'h1;
      @(negedge mclk_i);
      flags_clear_i = 1'h0;
      `CHK("clear", 2'h0, {timeout_status_flag_o, stop_flag_o})
      // timeout while stopped
      stop_mode_i = 1'h1;
      refresh_i = 1'h1;
      @(negedge mclk_i);
      refresh_i = 1'h0;
      wt(1'h1);
      `CHK("stop flags", 3'h6, {timeout_status_flag_o, stop_flag_o, sys_reset_req_o})
      // unlock bytes leave the control bits alone
      wr(`WDT_ADDR_CTL, 8'h55);
      wr(`WDT_ADDR_CTL, 8'hAA);
      idle();
      `CHK("ctl kept", 2'h3, {timeout_status_flag_o, stop_flag_o})
      rd_en_i = 1'h1;
      rd_addr_i = `WDT_ADDR_CTL;
      @(negedge mclk_i);
      rd_en_i = 1'h0;
      `CHK("ctl read", 8'h00, rd_data_o)
      stop_test();
   end
endmodule
bind wdt_core wdt_core_assertions chk_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .wr_en_i(wr_en_i),
   .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i),
   .rd_data_o(rd_data_o), .wdt_enable_i(wdt_enable_i), .refresh_i(refresh_i),
   .reset_on_timeout_i(reset_on_timeout_i), .stop_mode_i(stop_mode_i), .flags_clear_i(flags_clear_i),
   .sys_reset_req_o(sys_reset_req_o), .stop_recovery_o(stop_recovery_o),
   .timeout_status_flag_o(timeout_status_flag_o), .stop_flag_o(stop_flag_o), .counter_o(counter_o));
`default_nettype wire

// file: tb/wdt_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
// ==========================================
// port checker for the watchdog core
module wdt_core_assertions (
   // clock and reset
   input wire logic        mclk_i,
   input wire logic        nrst_i,
   // register ports
   input wire logic        wr_en_i,
   input wire logic [11:0] wr_addr_i,
   input wire logic [7:0]  wr_data_i,
   input wire logic        rd_en_i,
   input wire logic [11:0] rd_addr_i,
   input wire logic [7:0]  rd_data_o,
   // controls
   input wire logic        wdt_enable_i,
   input wire logic        refresh_i,
   input wire logic        reset_on_timeout_i,
   input wire logic        stop_mode_i,
   input wire logic        flags_clear_i,
   // results
   input wire logic        sys_reset_req_o,
   input wire logic        stop_recovery_o,
   input wire logic        timeout_status_flag_o,
   input wire logic        stop_flag_o,
   input wire logic [23:0] counter_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // last count, nothing reloading; past enable excludes the load cycle
   wire logic expire = counter_o == 24'h000001 && wdt_enable_i && !refresh_i && reset_on_timeout_i;
   a_normal_timeout: assert property (expire && $past(wdt_enable_i) && !stop_mode_i
      |=> sys_reset_req_o && timeout_status_flag_o && !stop_recovery_o) else $error("normal timeout missed");
   a_stop_timeout: assert property (expire && $past(wdt_enable_i) && stop_mode_i
      |=> stop_recovery_o && stop_flag_o && timeout_status_flag_o && !sys_reset_req_o) else $error("stop timeout missed");
   a_reset_cause: assert property (sys_reset_req_o |-> $past(counter_o) == 24'h000001
      && counter_o == 24'h000000 && !$past(stop_mode_i)) else $error("reset without expiry");
   a_reset_pulse: assert property (sys_reset_req_o |=> !sys_reset_req_o)
      else $error("reset request too long");
   a_stop_pair: assert property ($rose(stop_flag_o) |-> timeout_status_flag_o && stop_recovery_o)
      else $error("stop flag alone");
   a_flag_sticky: assert property (timeout_status_flag_o && !flags_clear_i |=> timeout_status_flag_o)
      else $error("status flag lost");
   a_count_down: assert property (wdt_enable_i && $past(wdt_enable_i) && !refresh_i && counter_o != 24'h0
      |=> counter_o == $past(counter_o) - 24'h000001) else $error("count step wrong");
   a_hold_zero: assert property (counter_o == 24'h0 && !refresh_i && !$rose(wdt_enable_i)
      |=> counter_o == 24'h0) else $error("counter left zero");
   a_ctl_read: assert property (rd_en_i && rd_addr_i == `WDT_ADDR_CTL |=> rd_data_o == 8'h00)
      else $error("control read not zero");
   // main scenarios reached
   cover property (sys_reset_req_o);
   cover property (stop_recovery_o);
   cover property (refresh_i && wdt_enable_i);
endmodule
`default_nettype wire
